// ### timer_cfg.svh
// Register offsets, field positions, reset values and constants.
// Assumes inclusion by the timer package and design files only.
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// Register indexes; byte address is four times the index
`define IDX_RUN 6'h00
`define IDX_WAVE 6'h01
`define IDX_FORCE 6'h02
`define IDX_SPLIT 6'h03
`define IDX_CMDCLR 6'h04
`define IDX_CMDSET 6'h05
`define IDX_BVCLR 6'h06
`define IDX_BVSET 6'h07
`define IDX_COUNT 6'h20
`define IDX_PERIOD 6'h26
`define IDX_CMP0 6'h28
`define IDX_PBUF 6'h36
`define IDX_CBUF0 6'h38

// Field positions
`define RUN_EN_BIT 0
`define RUN_SEL_LSB 1
`define WAVE_MODE_LSB 0
`define WAVE_AUTO_LOCK_UPDATE_BIT 3
`define WAVE_EN_LSB 4
`define CMD_DIR_BIT 0
`define CMD_LOCK_UPDATE_FLAG_BIT 1
`define CMD_FIELD_LSB 2

// Reset values
`define RUN_RST 8'h00
`define WAVE_RST 8'h00
`define FORCE_RST 3'h0
`define PERIOD_RST 16'hffff
`define CMP_RST 16'h0000

`endif

// ### timer_pkg.sv
// Types shared by the timer control block, its checker, the pin model and the bench.
// Assumes timer_cfg.svh holds the numeric constants.
package timer_pkg;

    // Waveform mode select codes; 0x2 and 0x4 are reserved
    typedef enum logic [2:0] {
        WG_NORMAL = 3'h0,
        WG_FREQ = 3'h1,
        WG_RSV2 = 3'h2,
        WG_ONE_SLOPE = 3'h3,
        WG_RSV4 = 3'h4,
        WG_DS_TOP = 3'h5,
        WG_DS_BOTH = 3'h6,
        WG_DS_LOW = 3'h7
    } waveMode_t;

    // Command field codes
    typedef enum logic [1:0] {
        CMD_NONE = 2'h0,
        CMD_UPDATE = 2'h1,
        CMD_RESTART = 2'h2,
        CMD_HARD_RESET = 2'h3
    } timerCmd_t;

    // Bus handshake states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } busState_t;

    // Waveform output bundle toward pads and logic unit
    typedef struct packed {
        logic [2:0] pad;
        logic [2:0] padOe;
        logic [2:0] cluLevel;
    } waveOut_t;

endpackage : timer_pkg

// ### timer_prescaler.sv
// Count clock prescaler: one-cycle tick at the selected division.
// Assumes a synchronous active-low reset from the parent.
`timescale 1ns/1ps
module timer_prescaler (
    input wire logic clk_sys,
    input wire logic rstSync_n,
    input wire logic enable,
    input wire logic [2:0] clkSel,
    output logic tick_r
);
    logic [9:0] divCnt_r; // Free divider while enabled
    logic [9:0] mask; // Low bits that must all be one

    // Division per select code: 1,2,4,8,16,64,256,1024
    always_comb
    begin
        unique case (clkSel)
            3'h0: mask = 10'h000;
            3'h1: mask = 10'h001;
            3'h2: mask = 10'h003;
            3'h3: mask = 10'h007;
            3'h4: mask = 10'h00f;
            3'h5: mask = 10'h03f;
            3'h6: mask = 10'h0ff;
            3'h7: mask = 10'h3ff;
        endcase
    end

    // Divider and tick; idle when disabled so restart is aligned
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            divCnt_r <= 10'h000;
            tick_r <= 1'b0;
        end
        else if (!enable)
        begin
            divCnt_r <= 10'h000;
            tick_r <= 1'b0;
        end
        else
        begin
            divCnt_r <= divCnt_r + 10'h001;
            tick_r <= ((divCnt_r & mask) == mask);
        end
    end
endmodule : timer_prescaler

// ### timer_update_waveform_control.sv
// 16-bit timer control: waveform modes, buffered update with auto-lock,
// commands, direction, forced outputs, split mode, set/clear aliases.
// Assumes an Avalon-MM master on clk_sys; pads and logic unit downstream.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "timer_cfg.svh"

module timer_update_waveform_control (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    output timer_pkg::waveOut_t waveOut,
    output logic updatePulse,
    output logic overflowPulse
);
    import timer_pkg::*;

    // Reset release synchroniser
    logic rstMeta_r;
    logic rstSync_n;

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstMeta_r <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_r <= 1'b1;
            rstSync_n <= rstMeta_r;
        end
    end

    // Address decode of one aligned word
    function automatic logic regHit(input logic [7:0] addr,
                                    input logic [5:0] idx);
        regHit = (addr[1:0] == 2'b00) && (addr[7:2] == idx);
    endfunction : regHit

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] laneMerge(input logic [15:0] old,
                                              input logic [15:0] data,
                                              input logic [1:0] be);
        laneMerge[7:0] = be[0] ? data[7:0] : old[7:0];
        laneMerge[15:8] = be[1] ? data[15:8] : old[15:8];
    endfunction : laneMerge

    // Control registers
    logic [7:0] runCtrl_r; // Enable and clock select
    logic [7:0] waveCfg_r; // Mode, auto-lock, output enables
    logic [2:0] forceVal_r; // Output force value readback
    logic splitMode_r; // split_mode_bit
    logic lockUpdate_r; // lock_update_flag
    logic countDown_r; // Direction: 1 counts down
    logic [3:0] bufValid_r; // {cmp2..0, period} valid flags
    logic [15:0] count_r; // Counter (split: {hi, lo})
    logic [15:0] periodValue_r;
    logic [15:0] periodBuf_r;
    logic [15:0] cmpValue_r [3];
    logic [15:0] cmpBuf_r [3];
    logic [2:0] waveLevel_r; // Waveform generator levels

    // Bus handshake
    busState_t busState_r;
    logic [31:0] readData_r;
    logic busTake; // Request completes this cycle
    logic wrTake;
    logic [15:0] wData;
    logic [1:0] wBe;

    assign busTake = (busState_r == BUS_ACK);
    assign wrTake = busTake && avsWrite;
    assign wData = avsWriteData[15:0];
    assign wBe = avsByteEnable[1:0];
    // Idle bit of the one-hot state is the wait flag, straight from a flop
    assign avsWaitRequest = busState_r[0];
    assign avsReadData = readData_r;

    // Decoded fields
    waveMode_t mode;
    logic timerOn;
    logic autoLock;
    logic [2:0] chanEn;
    logic [1:0] cmdCode;
    logic cmdWrite;
    logic forceUpd;
    logic doRestart;
    logic hardReset;

    assign mode = waveMode_t'(waveCfg_r[`WAVE_MODE_LSB +: 3]);
    assign timerOn = runCtrl_r[`RUN_EN_BIT];
    assign autoLock = waveCfg_r[`WAVE_AUTO_LOCK_UPDATE_BIT];
    assign chanEn = waveCfg_r[`WAVE_EN_LSB +: 3];
    assign cmdCode = wData[`CMD_FIELD_LSB +: 2];
    assign cmdWrite = wrTake && wBe[0] &&
        (regHit(avsAddress, `IDX_CMDCLR) || regHit(avsAddress, `IDX_CMDSET));
    assign forceUpd = cmdWrite && (cmdCode == CMD_UPDATE);
    assign doRestart = cmdWrite && (cmdCode == CMD_RESTART);
    assign hardReset = cmdWrite && (cmdCode == CMD_HARD_RESET) &&
        !timerOn;

    // Count tick from the prescaler
    logic tick;

    timer_prescaler prescaler (
        .clk_sys(clk_sys),
        .rstSync_n(rstSync_n),
        .enable(timerOn),
        .clkSel(runCtrl_r[`RUN_SEL_LSB +: 3]),
        .tick_r(tick)
    );

    // Slope decode and TOP selection
    logic dualSlope;
    logic pwmMode;
    logic [15:0] topVal;
    logic atTop;
    logic atLow;
    logic wrapHit;
    logic updEvent;
    logic ovfEvent;

    assign dualSlope = (mode == WG_DS_TOP) || (mode == WG_DS_BOTH) ||
        (mode == WG_DS_LOW);
    assign pwmMode = dualSlope || (mode == WG_ONE_SLOPE);
    assign topVal = (mode == WG_FREQ) ? cmpValue_r[0] : periodValue_r;
    assign atTop = !countDown_r && (count_r == topVal);
    assign atLow = countDown_r && (count_r == 16'h0000);
    assign wrapHit = atTop || atLow; // Single-slope wrap

    // Update and overflow points per mode; none in split mode
    always_comb
    begin
        updEvent = 1'b0;
        ovfEvent = 1'b0;
        if (tick && timerOn && !splitMode_r)
        begin
            if (dualSlope)
            begin
                updEvent = atLow;
                unique case (mode)
                    WG_DS_TOP: ovfEvent = atTop;
                    WG_DS_BOTH: ovfEvent = atTop || atLow;
                    default: ovfEvent = atLow;
                endcase
            end
            else
            begin
                updEvent = wrapHit;
                ovfEvent = wrapHit;
            end
        end
    end

    // Buffer transfer: unlocked update or forced update
    logic doTransfer;
    logic allValid;

    assign doTransfer = (updEvent && !lockUpdate_r) || forceUpd;
    assign allValid = &(bufValid_r[3:1] | ~chanEn);

    // Bus handshake: one wait cycle, then answer
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            busState_r <= BUS_IDLE;
        else
        begin
            unique case (busState_r)
                BUS_IDLE: if (avsRead || avsWrite) busState_r <= BUS_ACK;
                BUS_ACK: busState_r <= BUS_IDLE;
            endcase
        end
    end

    // Read data, registered in the wait cycle
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            readData_r <= 32'h0000_0000;
        else if (busState_r == BUS_IDLE && avsRead)
        begin
            readData_r <= 32'h0000_0000; // Unmapped reads zero
            if (regHit(avsAddress, `IDX_RUN))
                readData_r[7:0] <= runCtrl_r;
            if (regHit(avsAddress, `IDX_WAVE))
                readData_r[7:0] <= waveCfg_r;
            if (regHit(avsAddress, `IDX_FORCE))
                readData_r[2:0] <= forceVal_r;
            if (regHit(avsAddress, `IDX_SPLIT))
                readData_r[0] <= splitMode_r;
            if (regHit(avsAddress, `IDX_CMDCLR) ||
                regHit(avsAddress, `IDX_CMDSET))
                readData_r[1:0] <= {lockUpdate_r, countDown_r};
            if (regHit(avsAddress, `IDX_BVCLR) ||
                regHit(avsAddress, `IDX_BVSET))
                readData_r[3:0] <= bufValid_r;
            if (regHit(avsAddress, `IDX_COUNT))
                readData_r[15:0] <= count_r;
            if (regHit(avsAddress, `IDX_PERIOD))
                readData_r[15:0] <= periodValue_r;
            if (regHit(avsAddress, `IDX_PBUF))
                readData_r[15:0] <= periodBuf_r;
            for (int n = 0; n < 3; n++)
            begin
                if (regHit(avsAddress, `IDX_CMP0 + 6'(2 * n)))
                    readData_r[15:0] <= cmpValue_r[n];
                if (regHit(avsAddress, `IDX_CBUF0 + 6'(2 * n)))
                    readData_r[15:0] <= cmpBuf_r[n];
            end
        end
    end

    // Plain control registers
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            runCtrl_r <= `RUN_RST;
            waveCfg_r <= `WAVE_RST;
            forceVal_r <= `FORCE_RST;
            splitMode_r <= 1'b0;
        end
        else if (wrTake && wBe[0])
        begin
            if (regHit(avsAddress, `IDX_RUN))
                runCtrl_r <= wData[7:0] & 8'h0f;
            if (regHit(avsAddress, `IDX_WAVE))
                waveCfg_r <= wData[7:0] & 8'h7f;
            if (regHit(avsAddress, `IDX_FORCE))
                forceVal_r <= wData[2:0];
            if (regHit(avsAddress, `IDX_SPLIT))
                splitMode_r <= wData[0];
        end
    end

    // Lock flag: software aliases first, then auto-lock
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            lockUpdate_r <= 1'b0;
        else if (hardReset)
            lockUpdate_r <= 1'b0;
        else if (wrTake && wBe[0] && regHit(avsAddress, `IDX_CMDSET) &&
                 wData[`CMD_LOCK_UPDATE_FLAG_BIT])
            lockUpdate_r <= 1'b1;
        else if (wrTake && wBe[0] && regHit(avsAddress, `IDX_CMDCLR) &&
                 wData[`CMD_LOCK_UPDATE_FLAG_BIT])
            lockUpdate_r <= 1'b0;
        else if (wrTake && wBe[0] && regHit(avsAddress, `IDX_WAVE) &&
                 wData[`WAVE_AUTO_LOCK_UPDATE_BIT])
            lockUpdate_r <= 1'b1;
        else if (autoLock)
        begin
            if (lockUpdate_r && allValid)
                lockUpdate_r <= 1'b0;
            else if (!lockUpdate_r && updEvent)
                lockUpdate_r <= 1'b1;
        end
    end

    // Buffer valid flags; a buffer write wins over a clear
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            bufValid_r <= 4'h0;
        else if (hardReset)
            bufValid_r <= 4'h0;
        else
        begin
            logic [3:0] setMask;
            logic [3:0] clrMask;
            setMask = 4'h0;
            clrMask = doTransfer ? 4'hf : 4'h0;
            if (wrTake && !splitMode_r)
            begin
                if (regHit(avsAddress, `IDX_PBUF) && (|wBe))
                    setMask[0] = 1'b1;
                for (int n = 0; n < 3; n++)
                    if (regHit(avsAddress, `IDX_CBUF0 + 6'(2 * n)) &&
                        (|wBe))
                        setMask[n + 1] = 1'b1;
            end
            if (wrTake && wBe[0] && regHit(avsAddress, `IDX_BVSET))
                setMask = setMask | wData[3:0];
            if (wrTake && wBe[0] && regHit(avsAddress, `IDX_BVCLR))
                clrMask = clrMask | wData[3:0];
            bufValid_r <= (bufValid_r & ~clrMask) | setMask;
        end
    end

    // Period and compare: buffers, direct writes and transfer
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            periodValue_r <= `PERIOD_RST;
            periodBuf_r <= `PERIOD_RST;
            for (int n = 0; n < 3; n++)
            begin
                cmpValue_r[n] <= `CMP_RST;
                cmpBuf_r[n] <= `CMP_RST;
            end
        end
        else if (hardReset)
        begin
            // Kept apart from the async branch so reset stays a pure pin
            periodValue_r <= `PERIOD_RST;
            periodBuf_r <= `PERIOD_RST;
            for (int n = 0; n < 3; n++)
            begin
                cmpValue_r[n] <= `CMP_RST;
                cmpBuf_r[n] <= `CMP_RST;
            end
        end
        else
        begin
            if (doTransfer && bufValid_r[0])
                periodValue_r <= periodBuf_r;
            if (wrTake && regHit(avsAddress, `IDX_PERIOD))
                periodValue_r <= laneMerge(periodValue_r, wData, wBe);
            if (wrTake && regHit(avsAddress, `IDX_PBUF))
            begin
                if (splitMode_r) // Split map: no buffering
                    periodValue_r <= laneMerge(periodValue_r, wData, wBe);
                else
                    periodBuf_r <= laneMerge(periodBuf_r, wData, wBe);
            end
            for (int n = 0; n < 3; n++)
            begin
                if (doTransfer && bufValid_r[n + 1])
                    cmpValue_r[n] <= cmpBuf_r[n];
                if (wrTake && regHit(avsAddress, `IDX_CMP0 + 6'(2 * n)))
                    cmpValue_r[n] <= laneMerge(cmpValue_r[n], wData, wBe);
                if (wrTake && regHit(avsAddress, `IDX_CBUF0 + 6'(2 * n)))
                begin
                    if (splitMode_r)
                        cmpValue_r[n] <= laneMerge(cmpValue_r[n], wData,
                                                   wBe);
                    else
                        cmpBuf_r[n] <= laneMerge(cmpBuf_r[n], wData, wBe);
                end
            end
        end
    end

    // Counter and direction
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            count_r <= 16'h0000;
            countDown_r <= 1'b0;
        end
        else if (hardReset || doRestart)
        begin
            count_r <= 16'h0000;
            countDown_r <= 1'b0;
        end
        else
        begin
            if (tick && timerOn && splitMode_r)
            begin
                // Two 8-bit down counters, each reloading its period byte
                count_r[7:0] <= (count_r[7:0] == 8'h00) ?
                    periodValue_r[7:0] : count_r[7:0] - 8'h01;
                count_r[15:8] <= (count_r[15:8] == 8'h00) ?
                    periodValue_r[15:8] : count_r[15:8] - 8'h01;
            end
            else if (tick && timerOn)
            begin
                if (!countDown_r)
                begin
                    if (!atTop)
                        count_r <= count_r + 16'h0001;
                    else if (dualSlope)
                    begin
                        count_r <= count_r - 16'h0001;
                        countDown_r <= 1'b1;
                    end
                    else
                        count_r <= 16'h0000;
                end
                else
                begin
                    if (!atLow)
                        count_r <= count_r - 16'h0001;
                    else if (dualSlope)
                    begin
                        count_r <= count_r + 16'h0001;
                        countDown_r <= 1'b0;
                    end
                    else
                        count_r <= topVal;
                end
            end
            if (wrTake && regHit(avsAddress, `IDX_COUNT))
                count_r <= laneMerge(count_r, wData, wBe);
            // Software direction writes win over the slope turn
            if (wrTake && wBe[0] && regHit(avsAddress, `IDX_CMDSET) &&
                wData[`CMD_DIR_BIT])
                countDown_r <= 1'b1;
            else if (wrTake && wBe[0] && regHit(avsAddress, `IDX_CMDCLR) &&
                     wData[`CMD_DIR_BIT])
                countDown_r <= 1'b0;
        end
    end

    // Waveform generator levels
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            waveLevel_r <= 3'h0;
        else if (!timerOn)
        begin
            // Stopped: force writes drive levels directly
            if (wrTake && wBe[0] && regHit(avsAddress, `IDX_FORCE))
                waveLevel_r <= wData[2:0];
        end
        else if (splitMode_r)
        begin
            for (int n = 0; n < 3; n++)
                waveLevel_r[n] <= count_r[7:0] < cmpValue_r[n][7:0];
        end
        else if (mode == WG_FREQ)
        begin
            if (tick && wrapHit)
                waveLevel_r[0] <= !waveLevel_r[0];
        end
        else if (pwmMode)
        begin
            for (int n = 0; n < 3; n++)
                waveLevel_r[n] <= count_r < cmpValue_r[n];
        end
        // Normal and reserved modes hold levels: no waveform
    end

    // Registered outputs: pads gated by enables, logic unit ungated
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            waveOut <= '0;
            updatePulse <= 1'b0;
            overflowPulse <= 1'b0;
        end
        else
        begin
            waveOut.pad <= waveLevel_r & chanEn;
            waveOut.padOe <= chanEn;
            waveOut.cluLevel <= waveLevel_r;
            updatePulse <= updEvent || forceUpd;
            overflowPulse <= ovfEvent;
        end
    end
endmodule : timer_update_waveform_control

// ### timer_update_waveform_control_props.sv
// Checker for the timer control block's port behaviour.
// Assumes binding onto the top module; sees its ports only.
`timescale 1ns/1ps
module timer_update_waveform_control_props (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    input wire logic [31:0] avsReadData,
    input wire logic avsWaitRequest,
    input wire timer_pkg::waveOut_t waveOut,
    input wire logic updatePulse,
    input wire logic overflowPulse
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    // Answered read or write on either command alias
    logic rdCmd;
    logic wrUpd;
    assign rdCmd = avsRead & ~avsWaitRequest & (avsAddress[7:3] == 5'h02);
    assign wrUpd = avsWrite & ~avsWaitRequest & (avsAddress[7:3] == 5'h02)
        & avsByteEnable[0] & (avsWriteData[3:2] == 2'h1);
    chk_wait_one: assert property ((avsRead || avsWrite) && avsWaitRequest
        |=> !avsWaitRequest) else $error("no answer after one wait");
    chk_wait_pulse: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low too long");
    chk_pad_gated: assert property (waveOut.pad ==
        (waveOut.cluLevel & waveOut.padOe)) else $error("pad not gated");
    chk_cmd_zero: assert property (rdCmd |-> avsReadData[3:2] == 2'h0)
        else $error("command field read nonzero");
    chk_unmapped_zero: assert property (avsRead && !avsWaitRequest
        && avsAddress == 8'hfc |-> avsReadData == 32'h0)
        else $error("unmapped read nonzero");
    chk_upd_once: assert property (updatePulse |=> !updatePulse)
        else $error("update pulse too long");
    chk_ovf_once: assert property (overflowPulse |=> !overflowPulse)
        else $error("overflow pulse too long");
    chk_force_upd: assert property (wrUpd |-> ##[1:2] updatePulse)
        else $error("forced update gave no pulse");
    cover property (wrUpd);
    cover property (rdCmd);
    cover property (|waveOut.pad);
endmodule : timer_update_waveform_control_props

bind timer_update_waveform_control timer_update_waveform_control_props u_props (
    .clk_sys(clk_sys), .reset_n(reset_n), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .waveOut(waveOut),
    .updatePulse(updatePulse), .overflowPulse(overflowPulse)
);

// ### pin_port_model.sv
// Model of the port pins and the logic unit input.
// Assumes pads carry pull-ups while the timer does not drive them.
`timescale 1ns/1ps
module pin_port_model (
    input wire timer_pkg::waveOut_t waveOut,
    output logic [2:0] pinLevel,
    output logic [2:0] cluSeen
);
    // Undriven pad floats high through its pull-up
    assign pinLevel = (waveOut.pad & waveOut.padOe) | ~waveOut.padOe;
    // Logic unit sees the level whatever the enables
    assign cluSeen = waveOut.cluLevel;
endmodule : pin_port_model

// ### timer_update_waveform_control_tb.sv
// Self-checking bench for the timer control block.
// Assumes the checker is bound in and a pin model on the outputs.
`timescale 1ns/1ps
module timer_update_waveform_control_tb;
    import timer_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] avsAddress = 8'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h0;
    logic [3:0] avsByteEnable = 4'h3;
    logic [31:0] avsReadData;
    logic avsWaitRequest;
    waveOut_t waveOut;
    logic updatePulse;
    logic overflowPulse;
    logic [2:0] pinLevel;
    logic [2:0] cluSeen;
    int n_errors = 0;
    int checks = 0;
    int seed = 58;
    logic [31:0] r;
    logic [2:0] e;
    logic [2:0] f;
    int nUpd;
    int nOvf;
    always #5 clk_sys = ~clk_sys;
    timer_update_waveform_control DUT (.clk_sys(clk_sys), .reset_n(reset_n),
        .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
        .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .waveOut(waveOut), .updatePulse(updatePulse),
        .overflowPulse(overflowPulse));
    pin_port_model pins (.waveOut(waveOut), .pinLevel(pinLevel),
        .cluSeen(cluSeen));
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x)
        begin
            $display("BAD %s exp %h got %h", n, x, s);
            n_errors++;
        end
    endtask : chk
    task tally_and_finish;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    // Bounded wait for the edge that samples waitrequest low
    task waitAck;
        int i;
        i = 0;
        do
        begin
            @(posedge clk_sys);
            i++;
        end while (avsWaitRequest !== 1'b0 && i < 50);
        if (i >= 50)
        begin
            n_errors++;
            tally_and_finish;
        end
    endtask : waitAck
    task wr(input logic [7:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= 1'b1;
        waitAck;
        avsWrite <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task rc(input string n, input logic [7:0] a, input logic [31:0] x);
        avsAddress <= a;
        avsRead <= 1'b1;
        waitAck;
        chk(n, avsReadData, x);
        avsRead <= 1'b0;
        @(posedge clk_sys);
    endtask : rc
    // Pad level seen through a pulled-up pin
    function logic [2:0] pinExp(input logic [2:0] lv, input logic [2:0] en);
        return (lv & en) | ~en;
    endfunction : pinExp
    // Wrap pulses in a window of single-slope ticks at divide-by-one
    function int pulsesIn(input int win, input logic [15:0] period_value);
        return win / (int'(period_value) + 1);
    endfunction : pulsesIn
    initial
    begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rc("wave", 8'h04, 32'h0);
        rc("force", 8'h08, 32'h0);
        rc("cmd", 8'h10, 32'h0);
        rc("unmapped", 8'hfc, 32'h0);
        // Timer stopped: force bits drive levels, enables gate pads
        repeat (4)
        begin
            r = $random(seed);
            e = r[2:0];
            f = r[6:4];
            wr(8'h04, {25'h0, e, 4'h0});
            wr(8'h08, {29'h0, f});
            repeat (2) @(posedge clk_sys);
            chk("clu", 32'(cluSeen), 32'(f));
            chk("pin", 32'(pinLevel), 32'(pinExp(f, e)));
        end
        wr(8'h04, 32'h0);
        wr(8'h14, 32'h3);
        rc("set", 8'h10, 32'h3);
        wr(8'h10, 32'h1);
        rc("clr", 8'h14, 32'h2);
        wr(8'h14, 32'h1);
        wr(8'h14, 32'hc);
        rc("hrst", 8'h10, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h14, 32'h3);
        wr(8'h14, 32'hc);
        rc("hrst_on", 8'h10, 32'h3);
        wr(8'h14, 32'h8);
        rc("restart", 8'h10, 32'h2);
        wr(8'h00, 32'h0);
        wr(8'h10, 32'h2);
        r = $random(seed);
        wr(8'hd8, {16'h0, r[15:0]});
        rc("pbv", 8'h18, 32'h1);
        wr(8'h18, 32'h1);
        rc("pbv_clr", 8'h18, 32'h0);
        // Auto-lock on channel 0 holds until its buffer is written
        wr(8'h04, 32'h18);
        rc("alock", 8'h10, 32'h2);
        wr(8'he0, {16'h0, r[31:16]});
        rc("alock_rel", 8'h10, 32'h0);
        rc("cbv", 8'h18, 32'h2);
        wr(8'h14, 32'h4);
        rc("cmp0", 8'ha0, {16'h0, r[31:16]});
        rc("cbv_upd", 8'h18, 32'h0);
        // Single-slope run, period 3: one update and overflow per wrap
        wr(8'h98, 32'h3);
        wr(8'h80, 32'h0);
        wr(8'h04, 32'h73);
        wr(8'h00, 32'h1);
        repeat (8) @(posedge clk_sys);
        nUpd = 0;
        nOvf = 0;
        repeat (40)
        begin
            @(posedge clk_sys);
            nUpd += (updatePulse === 1'b1);
            nOvf += (overflowPulse === 1'b1);
        end
        chk("upd", nUpd, pulsesIn(40, 16'h3));
        chk("ovf", nOvf, pulsesIn(40, 16'h3));
        tally_and_finish;
    end
endmodule : timer_update_waveform_control_tb
